// [rtl/srr_regs.vh]
// Constants for the speed reference and ramp path: offsets, fields, reset values, timing.
// Assumes a 50 MHz clock and a plain one-cycle register port.
`ifndef SRR_REGS_VH
`define SRR_REGS_VH
`define SRR_CLK_HZ        50000000
`define SRR_FULL_SCALE    10000
`define SRR_PCT_LIMIT     30000
`define SRR_THR_LIMIT     10000
`define SRR_TIME_MIN      1
`define SRR_TIME_MAX      6000
`define SRR_S_MAX         100
`define SRR_RATE_MAX      1024
`define SRR_CYC_PER_LSB   (`SRR_CLK_HZ / 10 / `SRR_FULL_SCALE)
`define SRR_S_UNIT        (`SRR_CLK_HZ / 10 / `SRR_RATE_MAX)
`define SRR_OFS_CTRL      8'h00
`define SRR_OFS_REF_A     8'h04
`define SRR_OFS_REF_B     8'h08
`define SRR_OFS_REF_C     8'h0C
`define SRR_OFS_REF_D     8'h10
`define SRR_OFS_JOG       8'h14
`define SRR_OFS_LOCAL     8'h18
`define SRR_OFS_SEL_RB    8'h1C
`define SRR_OFS_GAIN_A    8'h20
`define SRR_OFS_SP_B      8'h24
`define SRR_OFS_GAIN_B    8'h28
`define SRR_OFS_SP_C      8'h2C
`define SRR_OFS_GAIN_C    8'h30
`define SRR_OFS_SP_D      8'h34
`define SRR_OFS_GAIN_D    8'h38
`define SRR_OFS_DEMAND    8'h3C
`define SRR_OFS_THR1      8'h40
`define SRR_OFS_THR2      8'h44
`define SRR_OFS_STATUS    8'h48
`define SRR_OFS_R1_IN     8'h4C
`define SRR_OFS_R1_OUT    8'h50
`define SRR_OFS_R2_IN     8'h54
`define SRR_OFS_R2_OUT    8'h58
`define SRR_OFS_TIMES     8'h80
`define SRR_CTRL_AUX_GATE 0
`define SRR_CTRL_SEL_HI   1
`define SRR_CTRL_SEL_LO   2
`define SRR_CTRL_SET1_B   3
`define SRR_CTRL_BYP1     4
`define SRR_CTRL_SET2_B   5
`define SRR_CTRL_BYP2     6
`define SRR_CTRL_R2_GATE  7
`define SRR_CTRL_RESET    8'h01
`define SRR_REF_A_RST     16'h0000
`define SRR_REF_B_RST     16'h03E8
`define SRR_REF_C_RST     16'h05DC
`define SRR_REF_D_RST     16'h07D0
`define SRR_JOG_RST       16'h01F4
`define SRR_LOCAL_RST     16'h0000
`define SRR_GAIN_RST      16'h2710
`define SRR_THR_RST       16'h0064
`define SRR_TIME_A_RST    16'h0032
`define SRR_TIME_B_RST    16'h000A
`define SRR_OPT_REMOTE_REF 2'h1
`endif

// [rtl/srr_top.v]
// Speed reference selection, two ramp generators and the setpoint sum.
// Assumes sequencer inputs synchronous to clk and a one-cycle register port.
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "srr_regs.vh"

module srr_ramp #(
  parameter REGEN_GATED = 1
) (
  input  wire               clk,
  input  wire               reset_n,
  input  wire               enable,
  input  wire               bypass,
  input  wire               set_b,
  input  wire               regen,
  input  wire [255:0]       times,
  input  wire signed [15:0] threshold,
  input  wire signed [15:0] ramp_in,
  output reg  signed [15:0] ramp_out_q,
  output reg                active_q,
  output reg                incr_q,
  output reg                decr_q
);
  localparam [31:0]  RATE_MAX_W = `SRR_RATE_MAX;
  reg  [10:0]        rate_q;
  reg  [31:0]        acc_q;
  reg  [19:0]        rc_q;
  wire signed [16:0] diff = {ramp_in[15], ramp_in} - {ramp_out_q[15], ramp_out_q};
  wire               up = diff > 17'sd0;
  wire [16:0]        mag = diff[16] ? (~diff + 17'd1) : diff;
  wire [7:0]         base = set_b ? 8'd128 : 8'd0;
  wire               fwd = up ? (ramp_out_q >= 16'sd0) : (ramp_out_q > 16'sd0);
  wire               accel = (up == fwd);
  wire               rev_ok = regen || (REGEN_GATED == 0);
  wire [15:0] fa  = times[base +: 16];
  wire [15:0] fd  = times[base + 8'd16 +: 16];
  wire [15:0] ra  = rev_ok ? times[base + 8'd32 +: 16] : fa;
  wire [15:0] rd  = rev_ok ? times[base + 8'd48 +: 16] : fd;
  wire [15:0] sab = times[base + 8'd64 +: 16];
  wire [15:0] sae = times[base + 8'd80 +: 16];
  wire [15:0] sdb = rev_ok ? times[base + 8'd96 +: 16] : 16'h0000;
  wire [15:0] sde = rev_ok ? times[base + 8'd112 +: 16] : 16'h0000;
  wire [15:0] t   = accel ? (fwd ? fa : ra) : (fwd ? fd : rd);
  wire [15:0] sb  = accel ? sab : sdb;
  wire [15:0] se  = accel ? sae : sde;
  // Full rate steps one LSB every t * CYC_PER_LSB cycles; acc runs RATE_MAX times finer
  wire [31:0] lim = t * (`SRR_CYC_PER_LSB * `SRR_RATE_MAX);
  wire [31:0] acc_n = acc_q + {21'd0, rate_q};
  wire [31:0] dist2 = {15'd0, mag} * {15'd0, t, 1'b0};
  wire        ending = (se != 16'h0000) && (dist2[31:0] <= se * `SRR_FULL_SCALE);
  // S times are clamped to 100, so the step length always fits 20 bits
  wire [31:0] s_prod = (ending ? se[7:0] : sb[7:0]) * `SRR_S_UNIT;
  wire [19:0] s_len = s_prod[19:0];
  wire        rc_hit = (rc_q + 20'd1 >= s_len);
  wire        dir_flip = (up && decr_q) || (!up && incr_q);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ramp_out_q <= 16'sh0000;
      rate_q     <= 11'h000;
      acc_q      <= 32'h0000_0000;
      rc_q       <= 20'h0_0000;
      active_q   <= 1'b0;
      incr_q     <= 1'b0;
      decr_q     <= 1'b0;
    end else begin
      active_q <= ({15'd0, mag} > {16'd0, threshold});
      if (!enable) begin
        ramp_out_q <= ramp_out_q;
      end else if (bypass) begin
        ramp_out_q <= ramp_in;
        rate_q     <= 11'h000;
        acc_q      <= 32'h0000_0000;
        incr_q     <= 1'b0;
        decr_q     <= 1'b0;
      end else if (diff == 17'sd0 || dir_flip) begin
        rate_q <= 11'h000;
        acc_q  <= 32'h0000_0000;
        rc_q   <= 20'h0_0000;
        incr_q <= 1'b0;
        decr_q <= 1'b0;
      end else begin
        incr_q <= up;
        decr_q <= !up;
        // Rate floor of one keeps the tail from stalling short of the input
        if (ending) begin
          rc_q <= rc_hit ? 20'h0_0000 : rc_q + 20'd1;
          if (rc_hit && rate_q > 11'd1) rate_q <= rate_q - 11'd1;
          else if (rate_q == 11'd0) rate_q <= 11'd1;
        end else if (rate_q < `SRR_RATE_MAX) begin
          if (sb == 16'h0000) begin
            rate_q <= RATE_MAX_W[10:0];
          end else begin
            rc_q <= rc_hit ? 20'h0_0000 : rc_q + 20'd1;
            if (rc_hit || rate_q == 11'd0) rate_q <= rate_q + 11'd1;
          end
        end
        if (acc_n >= lim) begin
          acc_q      <= acc_n - lim;
          ramp_out_q <= up ? ramp_out_q + 16'sd1 : ramp_out_q - 16'sd1;
        end else begin
          acc_q <= acc_n;
        end
      end
    end
  end
endmodule

module srr_top (
  input  wire               clk,
  input  wire               reset_n,
  input  wire [7:0]         reg_addr,
  input  wire [31:0]        reg_wdata,
  input  wire               reg_write,
  input  wire               reg_read,
  output reg  [31:0]        reg_rdata_q,
  input  wire               run_mode,
  input  wire               jog_mode,
  input  wire               local_mode,
  input  wire               drive_running,
  input  wire [1:0]         local_option_select,
  input  wire               sequencer_reference_gate,
  input  wire               sequencer_ramp_gate,
  input  wire               regen_variant,
  output reg  signed [15:0] selected_reference_readback,
  output reg  signed [19:0] velocity_demand,
  output wire signed [15:0] ramp_out_value,
  output wire [1:0]         ramp_direction_status,
  output wire               ramp_active
);
  reg  [7:0]         ctrl_q;
  reg  signed [15:0] pct_q [0:13];
  reg  [15:0]        time_q [0:31];
  reg  signed [15:0] thr1_q;
  reg  signed [15:0] thr2_q;
  reg  signed [15:0] ramp_in_value;
  reg  signed [15:0] r2_in_q;
  reg  signed [15:0] sel_d;
  wire signed [15:0] r2_out;
  wire               r2_act;
  wire               r2_inc;
  wire               r2_dec;
  wire [255:0]       times1;
  wire [255:0]       times2;
  wire               wr_pct = reg_write && reg_addr >= `SRR_OFS_REF_A && reg_addr <= `SRR_OFS_GAIN_D
                              && reg_addr != `SRR_OFS_SEL_RB;
  wire [3:0]         pct_idx = reg_addr[5:2] - 4'd1;
  wire               wr_time = reg_write && reg_addr >= `SRR_OFS_TIMES;
  wire [4:0]         time_idx = reg_addr[6:2];
  wire [1:0]         ref_choice = {ctrl_q[`SRR_CTRL_SEL_HI], ctrl_q[`SRR_CTRL_SEL_LO]};
  wire               aux_reference_gate = ctrl_q[`SRR_CTRL_AUX_GATE];
  wire               second_ramp_gate = ctrl_q[`SRR_CTRL_R2_GATE];

  // Percent operands are clamped on write so the sum cannot exceed its width
  function signed [15:0] clamp;
    input [31:0] v;
    input signed [31:0] lo;
    input signed [31:0] hi;
    begin
      if ($signed(v) < lo) clamp = lo[15:0];
      else if ($signed(v) > hi) clamp = hi[15:0];
      else clamp = v[15:0];
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_pack
      assign times1[g*16 +: 16] = time_q[g];
      assign times2[g*16 +: 16] = time_q[g + 16];
    end
  endgenerate

  always @(posedge clk or negedge reset_n) begin : p_regs
    integer i;
    if (!reset_n) begin
      ctrl_q   <= `SRR_CTRL_RESET;
      pct_q[0] <= `SRR_REF_A_RST;
      pct_q[1] <= `SRR_REF_B_RST;
      pct_q[2] <= `SRR_REF_C_RST;
      pct_q[3] <= `SRR_REF_D_RST;
      pct_q[4] <= `SRR_JOG_RST;
      pct_q[5] <= `SRR_LOCAL_RST;
      pct_q[6] <= 16'sh0000;
      for (i = 7; i < 14; i = i + 2) begin
        pct_q[i] <= `SRR_GAIN_RST;
      end
      for (i = 8; i < 14; i = i + 2) begin
        pct_q[i] <= 16'sh0000;
      end
      for (i = 0; i < 32; i = i + 1) begin
        time_q[i] <= ((i % 16) >= 8) ? 16'h0000 : ((i % 16) < 4) ? `SRR_TIME_A_RST : 16'h0000;
      end
      for (i = 8; i < 12; i = i + 1) begin
        time_q[i]      <= `SRR_TIME_B_RST;
        time_q[i + 16] <= `SRR_TIME_B_RST;
      end
      thr1_q  <= `SRR_THR_RST;
      thr2_q  <= `SRR_THR_RST;
      r2_in_q <= 16'sh0000;
    end else if (reg_write) begin
      if (reg_addr == `SRR_OFS_CTRL) ctrl_q <= reg_wdata[7:0];
      if (wr_pct) pct_q[pct_idx] <= clamp(reg_wdata, -`SRR_PCT_LIMIT, `SRR_PCT_LIMIT);
      if (wr_time) begin
        if (time_idx[2]) time_q[time_idx] <= clamp(reg_wdata, 0, `SRR_S_MAX);
        else time_q[time_idx] <= clamp(reg_wdata, `SRR_TIME_MIN, `SRR_TIME_MAX);
      end
      if (reg_addr == `SRR_OFS_THR1) thr1_q <= clamp(reg_wdata, 0, `SRR_THR_LIMIT);
      if (reg_addr == `SRR_OFS_THR2) thr2_q <= clamp(reg_wdata, 0, `SRR_THR_LIMIT);
      if (reg_addr == `SRR_OFS_R2_IN) r2_in_q <= clamp(reg_wdata, -`SRR_PCT_LIMIT, `SRR_PCT_LIMIT);
    end
  end

  always @* begin
    if (jog_mode) begin
      sel_d = pct_q[4];
    end else if (local_mode && local_option_select != `SRR_OPT_REMOTE_REF) begin
      sel_d = pct_q[5];
    end else begin
      case (ref_choice)
        2'b00:   sel_d = pct_q[0];
        2'b01:   sel_d = pct_q[1];
        2'b10:   sel_d = pct_q[2];
        2'b11:   sel_d = pct_q[3];
        default: sel_d = pct_q[0];
      endcase
    end
  end

  // Products are in hundredths squared; dividing by full scale returns hundredths
  wire signed [31:0] prod_a = ramp_out_value * pct_q[7];
  wire signed [31:0] prod_b = pct_q[8] * pct_q[9];
  wire signed [31:0] prod_c = pct_q[10] * pct_q[11];
  wire signed [31:0] prod_d = pct_q[12] * pct_q[13];
  wire signed [33:0] sum_p = prod_a + prod_b + prod_c + prod_d;
  wire signed [33:0] sum_s = sum_p / 34'sd10000;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      selected_reference_readback <= 16'sh0000;
      ramp_in_value               <= 16'sh0000;
      velocity_demand             <= 20'sh0_0000;
    end else begin
      selected_reference_readback <= sel_d;
      // The reference gate comes from the sequencer, which drops it when stopping; the aux gate is CTRL bit 0
      if (drive_running && (run_mode || jog_mode || local_mode)
          && sequencer_reference_gate && aux_reference_gate) begin
        ramp_in_value <= selected_reference_readback;
      end else begin
        ramp_in_value <= 16'sh0000;
      end
      velocity_demand <= sum_s[19:0];
    end
  end

  srr_ramp #(.REGEN_GATED(1)) u_ramp1 (
    .clk        (clk),
    .reset_n    (reset_n),
    .enable     (sequencer_ramp_gate),
    .bypass     (ctrl_q[`SRR_CTRL_BYP1]),
    .set_b      (ctrl_q[`SRR_CTRL_SET1_B]),
    .regen      (regen_variant),
    .times      (times1),
    .threshold  (thr1_q),
    .ramp_in    (ramp_in_value),
    .ramp_out_q (ramp_out_value),
    .active_q   (ramp_active),
    .incr_q     (ramp_direction_status[0]),
    .decr_q     (ramp_direction_status[1])
  );

  srr_ramp #(.REGEN_GATED(0)) u_ramp2 (
    .clk        (clk),
    .reset_n    (reset_n),
    .enable     (second_ramp_gate),
    .bypass     (ctrl_q[`SRR_CTRL_BYP2]),
    .set_b      (ctrl_q[`SRR_CTRL_SET2_B]),
    .regen      (1'b1),
    .times      (times2),
    .threshold  (thr2_q),
    .ramp_in    (r2_in_q),
    .ramp_out_q (r2_out),
    .active_q   (r2_act),
    .incr_q     (r2_inc),
    .decr_q     (r2_dec)
  );

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_read) begin
      if (reg_addr >= `SRR_OFS_TIMES) reg_rdata_q <= {16'h0000, time_q[time_idx]};
      else if (reg_addr >= `SRR_OFS_REF_A && reg_addr <= `SRR_OFS_GAIN_D
               && reg_addr != `SRR_OFS_SEL_RB)
        reg_rdata_q <= {{16{pct_q[pct_idx][15]}}, pct_q[pct_idx]};
      else case (reg_addr)
        `SRR_OFS_CTRL:   reg_rdata_q <= {24'h00_0000, ctrl_q};
        `SRR_OFS_SEL_RB: reg_rdata_q <= {{16{selected_reference_readback[15]}},
                                         selected_reference_readback};
        `SRR_OFS_DEMAND: reg_rdata_q <= {{12{velocity_demand[19]}}, velocity_demand};
        `SRR_OFS_THR1:   reg_rdata_q <= {16'h0000, thr1_q};
        `SRR_OFS_THR2:   reg_rdata_q <= {16'h0000, thr2_q};
        `SRR_OFS_STATUS: reg_rdata_q <= {26'h000_0000, r2_act, r2_dec, r2_inc, ramp_active,
                                         ramp_direction_status};
        `SRR_OFS_R1_IN:  reg_rdata_q <= {{16{ramp_in_value[15]}}, ramp_in_value};
        `SRR_OFS_R1_OUT: reg_rdata_q <= {{16{ramp_out_value[15]}}, ramp_out_value};
        `SRR_OFS_R2_IN:  reg_rdata_q <= {{16{r2_in_q[15]}}, r2_in_q};
        `SRR_OFS_R2_OUT: reg_rdata_q <= {{16{r2_out[15]}}, r2_out};
        default:         reg_rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// [testbench/srr_seq_model.sv]
// Sequencer stand-in: turns a command code into mode levels and the two gates.
// Assumes cmd changes just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module srr_seq_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [2:0] cmd,
  output logic            run_mode,
  output logic            jog_mode,
  output logic            local_mode,
  output logic            drive_running,
  output logic            sequencer_reference_gate,
  output logic            sequencer_ramp_gate
);
  // Codes: 0 stop, 1 run, 2 jog, 3 local, 4 quick stop
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {run_mode, jog_mode, local_mode} <= 3'h0;
      {drive_running, sequencer_reference_gate, sequencer_ramp_gate} <= 3'h0;
    end else begin
      run_mode      <= (cmd == 3'h1) || (cmd == 3'h4);
      jog_mode      <= (cmd == 3'h2);
      local_mode    <= (cmd == 3'h3);
      drive_running <= (cmd != 3'h0);
      // Stop drops the reference gate, quick stop only the ramp gate
      sequencer_reference_gate <= (cmd != 3'h0);
      sequencer_ramp_gate      <= (cmd != 3'h4);
    end
  end
endmodule
`default_nettype wire

// [testbench/srr_chk_sva.sv]
// Checker on srr_top ports: read window, ramp status, frozen and monotone output.
// Assumes it is bound into srr_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module srr_chk (
  input wire               clk,
  input wire               reset_n,
  input wire               reg_write,
  input wire               reg_read,
  input wire [31:0]        reg_rdata_q,
  input wire               run_mode,
  input wire               jog_mode,
  input wire               local_mode,
  input wire [1:0]         local_option_select,
  input wire               sequencer_ramp_gate,
  input wire signed [15:0] selected_reference_readback,
  input wire signed [19:0] velocity_demand,
  input wire signed [15:0] ramp_out_value,
  input wire [1:0]         ramp_direction_status,
  input wire               ramp_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata_q == 32'h0000_0000)
    else $error("read data outside its window");
  a_dir_exclusive: assert property (ramp_direction_status != 2'b11)
    else $error("ramp both rising and falling");
  a_freeze_hold: assert property (!sequencer_ramp_gate [*2] |=> $stable(ramp_out_value))
    else $error("disabled ramp output moved");
  a_rise_monotone: assert property (ramp_direction_status == 2'b01 |->
    ramp_out_value >= $past(ramp_out_value))
    else $error("rising ramp went down");
  a_fall_monotone: assert property (ramp_direction_status == 2'b10 |->
    ramp_out_value <= $past(ramp_out_value))
    else $error("falling ramp went up");
  a_select_stable: assert property ((!reg_write && $stable(run_mode)
    && $stable(jog_mode) && $stable(local_mode) && $stable(local_option_select)) [*2]
    |=> $stable(selected_reference_readback))
    else $error("selected reference moved without cause");
  a_demand_stable: assert property (($stable(ramp_out_value) && !reg_write) [*3]
    |=> $stable(velocity_demand))
    else $error("demand moved without cause");
  // A bypass jump or a direction reversal shows activity for a cycle with no status
  a_active_moves: assert property ($past(sequencer_ramp_gate) && sequencer_ramp_gate
    && ramp_active |-> ramp_direction_status != 2'b00 || !$stable(ramp_out_value)
    || $past(ramp_direction_status) != 2'b00)
    else $error("active ramp shows no direction");
  c_falling: cover property (ramp_direction_status == 2'b10);
endmodule
bind srr_top srr_chk i_srr_chk (.clk, .reset_n, .reg_write, .reg_read, .reg_rdata_q,
  .run_mode, .jog_mode, .local_mode, .local_option_select, .sequencer_ramp_gate,
  .selected_reference_readback, .velocity_demand, .ramp_out_value,
  .ramp_direction_status, .ramp_active);
`default_nettype wire

// [testbench/srr_top_tb.sv]
// Bench for srr_top: register reads scored through a queue, ramp timing at the ports.
// Assumes times of 0.1 s give 500 cycles per step of one hundredth of a percent.
`timescale 1ns/100ps
`default_nettype none
`include "srr_regs.vh"
module srr_top_tb;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic [7:0]        reg_addr = 8'h00;
  logic [31:0]       reg_wdata = 32'h0000_0000;
  logic              reg_write = 1'b0;
  logic              reg_read = 1'b0;
  logic [2:0]        cmd = 3'h0;
  logic [1:0]        lopt = 2'h0;
  logic              regen = 1'b0;
  wire  [31:0]       rdata;
  wire               run_m, jog_m, loc_m, running, ref_gate, ramp_gate, act;
  wire signed [15:0] sel_rb, rout;
  wire signed [19:0] demand;
  wire  [1:0]        dir;
  logic [31:0]       exp_q[$];
  logic [7:0]        adr_q[$];
  logic              rd_pend = 1'b0;
  int                error_cnt = 0;
  int                num_checks = 0;
  int                cycles = 0;
  integer            seed = 32'hfdb5;
  logic [31:0]       v;
  srr_seq_model i_srr_seq_model (.clk(clk), .reset_n(reset_n), .cmd(cmd), .run_mode(run_m),
    .jog_mode(jog_m), .local_mode(loc_m), .drive_running(running),
    .sequencer_reference_gate(ref_gate), .sequencer_ramp_gate(ramp_gate));
  srr_top i_srr_top (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(rdata), .run_mode(run_m),
    .jog_mode(jog_m), .local_mode(loc_m), .drive_running(running),
    .local_option_select(lopt), .sequencer_reference_gate(ref_gate),
    .sequencer_ramp_gate(ramp_gate), .regen_variant(regen),
    .selected_reference_readback(sel_rb), .velocity_demand(demand),
    .ramp_out_value(rout), .ramp_direction_status(dir), .ramp_active(act));
  always #10 clk = ~clk;
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Read data is taken by the watcher one edge later, oldest note first
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rd_pend)
      chk($sformatf("reg %h", adr_q.pop_front()), exp_q.pop_front(), rdata);
    rd_pend <= reg_read;
    if (cycles == 60000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    adr_q.push_back(a);
    exp_q.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
  endtask
  // Steps land every 500*t cycles; sample halfway between steps
  task automatic ramp_chk(input int t, input int start, input int dn, input int n);
    cyc(250 * t);
    for (int k = 1; k <= n; k++) begin
      cyc(500 * t);
      chk("ramp out", start + dn * k, rout);
    end
  endtask
  logic [7:0]  ta[12] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h40,
                          8'h80, 8'hA0, 8'h90, 8'h7C};
  logic [31:0] te[12] = '{32'h1, 32'h3E8, 32'h5DC, 32'h7D0, 32'h1F4, 32'h0, 32'h2710,
                          32'h64, 32'h32, 32'hA, 32'h0, 32'h0};
  initial begin
    cyc(3);
    reset_n <= 1'b1;
    for (int i = 0; i < 12; i++)
      rd(ta[i], te[i]);
    $display("test presets done");
    cmd <= 3'h4;
    for (int s = 0; s < 4; s++) begin
      v = $random(seed) % 30000;
      wr(8'h04 + 8'(4 * s), v);
      wr(8'h00, {29'h0, s[0], s[1], 1'b1});
      rd(8'h1C, v);
    end
    wr(8'h10, 32'h0000_9C40);
    rd(8'h10, 32'h0000_7530);
    chk("sel port", 32'h7530, sel_rb);
    wr(8'h18, 32'h0000_004D);
    cmd <= 3'h2;
    // Mode levels leave the sequencer one edge after the command
    cyc(1);
    rd(8'h1C, 32'h1F4);
    cmd <= 3'h3;
    wr(8'h1C, 32'h0000_1234);
    rd(8'h1C, 32'h4D);
    lopt <= 2'h1;
    rd(8'h1C, 32'h7530);
    $display("test select done");
    cmd <= 3'h4;
    wr(8'h00, 32'h0000_0001);
    for (int i = 0; i < 4; i++)
      wr(8'h80 + 8'(4 * i), i < 2 ? 32'h1 : 32'h1770);
    wr(8'h04, 32'hFFFF_FFFE);
    cmd <= 3'h1;
    ramp_chk(1, 0, -1, 2);
    wr(8'h40, 32'h0);
    wr(8'h04, 32'h3);
    cyc(20);
    chk("active", 1, act);
    ramp_chk(1, -2, 1, 5);
    chk("dir idle", 0, dir);
    $display("test ramp done");
    wr(8'hA0, 32'h2);
    wr(8'hA4, 32'h1);
    wr(8'h00, 32'h0000_0009);
    wr(8'h04, 32'h5);
    ramp_chk(2, 3, 1, 2);
    cmd <= 3'h0;
    cyc(100);
    chk("dir down", 2, dir);
    rd(8'h4C, 32'h0);
    ramp_chk(1, 5, -1, 2);
    cmd <= 3'h4;
    cyc(1200);
    chk("frozen", 3, rout);
    $display("test stop done");
    cmd <= 3'h1;
    wr(8'h24, 32'hC8);
    wr(8'h28, 32'h1388);
    wr(8'h04, 32'h3E8);
    wr(8'h00, 32'h0000_0019);
    cyc(6);
    chk("bypass", 32'h3E8, rout);
    chk("demand", 32'h44C, demand);
    wr(8'h00, 32'h0000_0018);
    cyc(6);
    chk("aux gate", 0, rout);
    $display("test bypass done");
    wr(8'h54, 32'h2);
    wr(8'hC0, 32'h1);
    cyc(600);
    rd(8'h58, 32'h0);
    wr(8'h00, 32'h0000_0080);
    cyc(1300);
    rd(8'h58, 32'h2);
    wr(8'hD0, 32'h1);
    wr(8'h54, 32'h4);
    cyc(1300);
    rd(8'h58, 32'h2);
    regen <= 1'b1;
    wr(8'h04, 32'hFFFF_FFFE);
    wr(8'h00, 32'h0000_0081);
    cyc(800);
    chk("regen rev", 0, rout);
    cyc(3);
    $display("test second ramp done");
    summarize();
  end
endmodule
`default_nettype wire
